// file: design/ata_write_pkg.sv
// Constants, register indices and state type for the ATA PIO write command block.
// Assumes a 10 MHz mclk and an APB master that places each task-file register on a word.
//
// Contract
// - Block size of one sector is always accepted.
// - BSY rises within 400 ns of acceptance.
// - Multiple write interrupts per block, else like single.
// - DRQ raised only at each block start.
// - Full blocks, then partial block of count mod size.
// - Multiple write aborts if unprogrammed or disabled.
// - Error posted after block; stops at failing sector.
// - Interrupt when DRQ rises at each block start but the first.
// - On error: failing address, residual sector count.
// - Opcode CDh is multiple write without erase.
// - Opcodes 30h/31h write 1..256; zero means 256.
// - LBA from drive/head, cylinder and sector registers.
// - Single write: BSY, then DRQ, no first interrupt.
// - Per sector: BSY, then DRQ with interrupt.
// - After last sector BSY until done, then interrupt.
// - Error leaves failing sector address in registers.
// - Opcode 38h is sector write without erase.
// - Opcode C5h is the multiple write command.
// - Not pre-erased sector gets an ordinary write.
package ata_write_pkg;

  // ----------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_FEATURE = 4'h1;
  localparam logic [3:0] IDX_COUNT = 4'h2;
  localparam logic [3:0] IDX_SECNUM = 4'h3;
  localparam logic [3:0] IDX_CYL_LO = 4'h4;
  localparam logic [3:0] IDX_CYL_HI = 4'h5;
  localparam logic [3:0] IDX_DRVHD = 4'h6;
  localparam logic [3:0] IDX_CMD = 4'h7;
  localparam logic [3:0] IDX_MULTI_CFG = 4'h8;

  // ----------------------------------------------------------------
  // Opcodes.
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_SEC = 8'h30;
  localparam logic [7:0] OP_WRITE_SEC_NR = 8'h31;
  localparam logic [7:0] OP_WRITE_SEC_NOERASE = 8'h38;
  localparam logic [7:0] OP_WRITE_MULTI = 8'hC5;
  localparam logic [7:0] OP_WRITE_MULTI_NOERASE = 8'hCD;

  // ----------------------------------------------------------------
  // Field positions and reset values.
  // ----------------------------------------------------------------
  localparam int ST_BIT_BSY = 7;
  localparam int ST_BIT_DRDY = 6;
  localparam int ST_BIT_DRQ = 3;
  localparam int ST_BIT_ERR = 0;
  localparam int ER_BIT_MEDIA = 6;
  localparam int ER_BIT_ABRT = 2;
  localparam int DH_BIT_LBA = 6;
  localparam int CFG_BIT_EN = 8;
  localparam logic [7:0] DRVHD_RESET = 8'hA0;
  localparam logic [7:0] COUNT_RESET = 8'h01;
  localparam logic [7:0] SECNUM_RESET = 8'h01;

  // ----------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 100;
  localparam int BSY_MAX_NS = 400;
  localparam int BSY_MAX_CYC = BSY_MAX_NS / MCLK_PERIOD_NS;
  localparam int WORDS_PER_SECTOR = 256;
  localparam int MAX_SECTORS = 256;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACCEPT,
    ST_WAIT_BUF,
    ST_XFER,
    ST_FLASH
  } wr_state_e;

endpackage

// file: design/lba_step.sv
// Next sector address of the 28-bit task-file address.
// Assumes the caller decides when the step is taken.
`timescale 1ns/1ns
`default_nettype none
module lba_step (
  // Current address
  input wire logic [27:0] lba_cur,
  // Following address
  output logic [27:0] lba_next
);

  // The address wraps at the top of the 28-bit space rather than faulting.
  assign lba_next = lba_cur + 28'h000_0001;

endmodule
`default_nettype wire

// file: design/ata_pio_sector_write.sv
// ATA PIO sector and multiple write engine with an APB task-file slave.
// Assumes a sector buffer taking one 16-bit word per pulse and a flash engine
// that answers each start pulse with a done pulse, all on mclk.
`timescale 1ns/1ns
`default_nettype none
module ata_pio_sector_write
  import ata_write_pkg::*;
#(
  parameter int MAX_BLOCK = 128,
  parameter int SECTOR_WORDS = WORDS_PER_SECTOR
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Host interrupt line
  output logic intrq,
  // Sector buffer
  input wire logic buf_ready,
  output logic [15:0] buf_wdata,
  output logic buf_wvalid,
  // Flash write engine
  input wire logic flash_done,
  input wire logic flash_error,
  output logic flash_start,
  output logic [27:0] flash_lba,
  output logic flash_lba_mode,
  output logic flash_no_erase
);

  localparam int WORD_W = $clog2(SECTOR_WORDS);
  localparam logic [WORD_W-1:0] WORD_LAST = WORD_W'(SECTOR_WORDS - 1);
  localparam logic [8:0] MAX_BLOCK_V = 9'(MAX_BLOCK);

  // ----------------------------------------------------------------
  // Elaboration checks.
  // ----------------------------------------------------------------
  initial begin
    if (MAX_BLOCK < 1 || MAX_BLOCK > 255) $error("MAX_BLOCK must lie in 1..255");
    if (SECTOR_WORDS < 2 || (1 << WORD_W) != SECTOR_WORDS) begin
      $error("SECTOR_WORDS must be a power of two");
    end
    if (BSY_MAX_CYC < 1) $error("clock too slow to raise BSY in time");
  end

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  wr_state_e st_r, st_nxt;
  logic bsy_r, bsy_nxt;
  logic drq_r, drq_nxt;
  logic err_r, err_nxt;
  logic [7:0] errreg_r, errreg_nxt;
  logic intrq_r, intrq_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [7:0] secn_r, secn_nxt;
  logic [7:0] cyll_r, cyll_nxt;
  logic [7:0] cylh_r, cylh_nxt;
  logic [7:0] dh_r, dh_nxt;
  logic mcfg_en_r, mcfg_en_nxt;
  logic [7:0] mblk_r, mblk_nxt;
  logic multi_r, multi_nxt;
  logic noerase_r, noerase_nxt;
  logic first_r, first_nxt;
  logic [8:0] remain_r, remain_nxt;
  logic [8:0] blk_left_r, blk_left_nxt;
  logic [WORD_W-1:0] word_r, word_nxt;
  logic err_pend_r, err_pend_nxt;
  logic pready_r, pready_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [15:0] buf_wdata_r, buf_wdata_nxt;
  logic buf_wvalid_r, buf_wvalid_nxt;
  logic flash_start_r, flash_start_nxt;
  logic [27:0] flash_lba_r, flash_lba_nxt;
  logic flash_lba_mode_r, flash_lba_mode_nxt;
  logic flash_no_erase_r, flash_no_erase_nxt;
  logic [27:0] lba_cur;
  logic [27:0] lba_inc;
  logic [3:0] idx;
  logic unmapped;
  logic stall;
  logic done_wr;
  logic done_rd;
  logic [7:0] status;
  logic [8:0] blk_len;
  logic is_multi;
  logic is_single;
  // Address formed from drive/head low nibble and the three address bytes.
  assign lba_cur = {dh_r[3:0], cylh_r, cyll_r, secn_r};
  lba_step u_step (
    .lba_cur(lba_cur),
    .lba_next(lba_inc)
  );
  assign idx = paddr[5:2];
  assign unmapped = (idx > IDX_MULTI_CFG);
  // Mid-block the flash write runs with DRQ still up; data writes wait on pready.
  assign stall = (idx == IDX_DATA) && pwrite && (st_r == ST_FLASH);
  assign done_wr = psel && penable && pready_r && pwrite;
  assign done_rd = psel && penable && pready_r && !pwrite;
  assign status = {bsy_r, !bsy_r, 1'b0, 1'b0, drq_r, 1'b0, 1'b0, err_r};
  assign is_multi = (pwdata[7:0] == OP_WRITE_MULTI) || (pwdata[7:0] == OP_WRITE_MULTI_NOERASE);
  assign is_single = (pwdata[7:0] == OP_WRITE_SEC) || (pwdata[7:0] == OP_WRITE_SEC_NR)
    || (pwdata[7:0] == OP_WRITE_SEC_NOERASE);
  // Partial last block is simply what remains once full blocks are spent.
  assign blk_len = (remain_r < {1'b0, mblk_r}) ? remain_r : {1'b0, mblk_r};

  // ----------------------------------------------------------------
  // Next-state logic.
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    bsy_nxt = bsy_r;
    drq_nxt = drq_r;
    err_nxt = err_r;
    errreg_nxt = errreg_r;
    intrq_nxt = intrq_r;
    cnt_nxt = cnt_r;
    secn_nxt = secn_r;
    cyll_nxt = cyll_r;
    cylh_nxt = cylh_r;
    dh_nxt = dh_r;
    mcfg_en_nxt = mcfg_en_r;
    mblk_nxt = mblk_r;
    multi_nxt = multi_r;
    noerase_nxt = noerase_r;
    first_nxt = first_r;
    remain_nxt = remain_r;
    blk_left_nxt = blk_left_r;
    word_nxt = word_r;
    err_pend_nxt = err_pend_r;
    pready_nxt = psel && penable && !pready_r && !stall;
    prdata_nxt = prdata_r;
    pslverr_nxt = psel && penable && !pready_r && unmapped;
    buf_wdata_nxt = buf_wdata_r;
    buf_wvalid_nxt = 1'b0;
    flash_start_nxt = 1'b0;
    flash_lba_nxt = flash_lba_r;
    flash_lba_mode_nxt = flash_lba_mode_r;
    flash_no_erase_nxt = flash_no_erase_r;
    // Register reads; reading status acknowledges the interrupt.
    if (psel && penable && !pready_r && !pwrite) begin
      case (idx)
        IDX_FEATURE: prdata_nxt = {24'h00_0000, errreg_r};
        IDX_COUNT: prdata_nxt = {24'h00_0000, cnt_r};
        IDX_SECNUM: prdata_nxt = {24'h00_0000, secn_r};
        IDX_CYL_LO: prdata_nxt = {24'h00_0000, cyll_r};
        IDX_CYL_HI: prdata_nxt = {24'h00_0000, cylh_r};
        IDX_DRVHD: prdata_nxt = {24'h00_0000, dh_r};
        IDX_CMD: prdata_nxt = {24'h00_0000, status};
        IDX_MULTI_CFG: prdata_nxt = {23'h00_0000, mcfg_en_r, mblk_r};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (done_rd && idx == IDX_CMD) begin
      intrq_nxt = 1'b0;
    end
    // Task-file writes are ignored while a command owns the registers.
    if (done_wr && !bsy_r && !drq_r) begin
      case (idx)
        IDX_COUNT: cnt_nxt = pwdata[7:0];
        IDX_SECNUM: secn_nxt = pwdata[7:0];
        IDX_CYL_LO: cyll_nxt = pwdata[7:0];
        IDX_CYL_HI: cylh_nxt = pwdata[7:0];
        IDX_DRVHD: dh_nxt = pwdata[7:0];
        IDX_MULTI_CFG: begin
          mcfg_en_nxt = pwdata[CFG_BIT_EN];
          // One sector always fits; oversize blocks count as unprogrammed.
          mblk_nxt = ({1'b0, pwdata[7:0]} <= MAX_BLOCK_V) ? pwdata[7:0] : 8'h00;
        end
        IDX_CMD: begin
          intrq_nxt = 1'b0;
          errreg_nxt = 8'h00;
          err_nxt = 1'b0;
          noerase_nxt = (pwdata[7:0] == OP_WRITE_SEC_NOERASE)
            || (pwdata[7:0] == OP_WRITE_MULTI_NOERASE);
          multi_nxt = is_multi;
          remain_nxt = (cnt_r == 8'h00) ? 9'(MAX_SECTORS) : {1'b0, cnt_r};
          first_nxt = 1'b1;
          err_pend_nxt = 1'b0;
          if (is_multi && (!mcfg_en_r || mblk_r == 8'h00)) begin
            err_nxt = 1'b1;
            errreg_nxt[ER_BIT_ABRT] = 1'b1;
            intrq_nxt = 1'b1;
          end else if (is_multi || is_single) begin
            bsy_nxt = 1'b1;
            st_nxt = ST_ACCEPT;
          end else begin
            err_nxt = 1'b1;
            errreg_nxt[ER_BIT_ABRT] = 1'b1;
            intrq_nxt = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    case (st_r)
      ST_IDLE: begin
      end
      ST_ACCEPT: begin
        st_nxt = ST_WAIT_BUF;
      end
      ST_WAIT_BUF: begin
        if (buf_ready) begin
          bsy_nxt = 1'b0;
          drq_nxt = 1'b1;
          // No interrupt opens the first block; every later DRQ rise brings one.
          if (!first_r) begin
            intrq_nxt = 1'b1;
          end
          first_nxt = 1'b0;
          blk_left_nxt = multi_r ? blk_len : 9'h001;
          word_nxt = '0;
          st_nxt = ST_XFER;
        end
      end
      ST_XFER: begin
        // Data is only taken while DRQ stands, so early host writes are dropped.
        if (done_wr && idx == IDX_DATA) begin
          buf_wdata_nxt = pwdata[15:0];
          buf_wvalid_nxt = 1'b1;
          word_nxt = word_r + WORD_W'(1);
          if (word_r == WORD_LAST) begin
            st_nxt = ST_FLASH;
            if (!multi_r || blk_left_r == 9'h001) begin
              bsy_nxt = 1'b1;
              drq_nxt = 1'b0;
            end
            // After a failure the rest of the block is absorbed, not written.
            flash_start_nxt = !err_pend_r;
            flash_lba_nxt = lba_cur;
            flash_lba_mode_nxt = dh_r[DH_BIT_LBA];
            flash_no_erase_nxt = noerase_r;
          end
        end
      end
      ST_FLASH: begin
        if ((flash_done && !flash_start_r) || err_pend_r) begin
          blk_left_nxt = blk_left_r - 9'h001;
          if (err_pend_r || flash_error) begin
            // Address and residual freeze on the failing sector.
            err_pend_nxt = 1'b1;
            cnt_nxt = remain_r[7:0];
            if (!multi_r || blk_left_r == 9'h001) begin
              bsy_nxt = 1'b0;
              drq_nxt = 1'b0;
              err_nxt = 1'b1;
              errreg_nxt[ER_BIT_MEDIA] = 1'b1;
              intrq_nxt = 1'b1;
              st_nxt = ST_IDLE;
            end else begin
              word_nxt = '0;
              st_nxt = ST_XFER;
            end
          end else begin
            remain_nxt = remain_r - 9'h001;
            cnt_nxt = 8'(remain_r - 9'h001);
            if (remain_r == 9'h001) begin
              bsy_nxt = 1'b0;
              drq_nxt = 1'b0;
              intrq_nxt = 1'b1;
              st_nxt = ST_IDLE;
            end else begin
              {dh_nxt[3:0], cylh_nxt, cyll_nxt, secn_nxt} = lba_inc;
              word_nxt = '0;
              if (!multi_r || blk_left_r == 9'h001) begin
                st_nxt = ST_WAIT_BUF;
              end else begin
                st_nxt = ST_XFER;
              end
            end
          end
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      bsy_r <= 1'b0;
      drq_r <= 1'b0;
      err_r <= 1'b0;
      errreg_r <= 8'h00;
      intrq_r <= 1'b0;
      cnt_r <= COUNT_RESET;
      secn_r <= SECNUM_RESET;
      cyll_r <= 8'h00;
      cylh_r <= 8'h00;
      dh_r <= DRVHD_RESET;
      mcfg_en_r <= 1'b0;
      mblk_r <= 8'h00;
      multi_r <= 1'b0;
      noerase_r <= 1'b0;
      first_r <= 1'b0;
      remain_r <= 9'h000;
      blk_left_r <= 9'h000;
      word_r <= '0;
      err_pend_r <= 1'b0;
      pready_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      buf_wdata_r <= 16'h0000;
      buf_wvalid_r <= 1'b0;
      flash_start_r <= 1'b0;
      flash_lba_r <= 28'h000_0000;
      flash_lba_mode_r <= 1'b0;
      flash_no_erase_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bsy_r <= bsy_nxt;
      drq_r <= drq_nxt;
      err_r <= err_nxt;
      errreg_r <= errreg_nxt;
      intrq_r <= intrq_nxt;
      cnt_r <= cnt_nxt;
      secn_r <= secn_nxt;
      cyll_r <= cyll_nxt;
      cylh_r <= cylh_nxt;
      dh_r <= dh_nxt;
      mcfg_en_r <= mcfg_en_nxt;
      mblk_r <= mblk_nxt;
      multi_r <= multi_nxt;
      noerase_r <= noerase_nxt;
      first_r <= first_nxt;
      remain_r <= remain_nxt;
      blk_left_r <= blk_left_nxt;
      word_r <= word_nxt;
      err_pend_r <= err_pend_nxt;
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      buf_wdata_r <= buf_wdata_nxt;
      buf_wvalid_r <= buf_wvalid_nxt;
      flash_start_r <= flash_start_nxt;
      flash_lba_r <= flash_lba_nxt;
      flash_lba_mode_r <= flash_lba_mode_nxt;
      flash_no_erase_r <= flash_no_erase_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign intrq = intrq_r;
  assign buf_wdata = buf_wdata_r;
  assign buf_wvalid = buf_wvalid_r;
  assign flash_start = flash_start_r;
  assign flash_lba = flash_lba_r;
  assign flash_lba_mode = flash_lba_mode_r;
  assign flash_no_erase = flash_no_erase_r;

endmodule
`default_nettype wire

// file: sim/ata_write_sva.sv
// Port assertions for the ATA PIO write command block.
// Assumes it is bound to every instance of ata_pio_sector_write.
`timescale 1ns/1ns
`default_nettype none
module ata_write_sva
  import ata_write_pkg::*;
#(
  parameter int MAX_BLOCK = 128,
  parameter int SECTOR_WORDS = WORDS_PER_SECTOR
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic intrq,
  // Buffer and flash
  input wire logic [15:0] buf_wdata,
  input wire logic buf_wvalid,
  input wire logic flash_start,
  input wire logic [27:0] flash_lba,
  input wire logic flash_no_erase
);
  // ----------------------------------------------------------------
  // Helper state
  // ----------------------------------------------------------------
  localparam logic [8:0] LAST = 9'(SECTOR_WORDS - 1);
  logic [8:0] wcnt_r, wcnt_nxt;
  logic pend_r, pend_nxt, sec_ok;
  logic [7:0] op_r, op_nxt;
  // A sector counts as whole on the cycle of its last word too, in case the
  // start pulse is launched by that same word.
  assign sec_ok = pend_r | (buf_wvalid & (wcnt_r == LAST));
  always_comb begin
    wcnt_nxt = wcnt_r;
    pend_nxt = pend_r;
    op_nxt = op_r;
    if (buf_wvalid) begin
      wcnt_nxt = (wcnt_r == LAST) ? 9'h000 : wcnt_r + 9'h001;
      pend_nxt = sec_ok;
    end
    if (flash_start) pend_nxt = 1'b0;
    if (psel && penable && pready && pwrite && paddr[5:2] == IDX_CMD) op_nxt = pwdata[7:0];
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      wcnt_r <= 9'h000;
      pend_r <= 1'b0;
      op_r <= 8'h00;
    end else begin
      wcnt_r <= wcnt_nxt;
      pend_r <= pend_nxt;
      op_r <= op_nxt;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("pready held longer than one cycle");
  property p_ready_cause; pready |-> $past(psel && penable); endproperty
  a_ready_cause: assert property (p_ready_cause)
    else $error("pready without an access phase");
  property p_word_cause;
    buf_wvalid |-> $past(psel && pready && pwrite && paddr[5:2] == IDX_DATA)
      && buf_wdata == $past(pwdata[15:0]);
  endproperty
  a_word_cause: assert property (p_word_cause)
    else $error("buffer word not from a data port write");
  property p_start_pulse; flash_start |=> !flash_start; endproperty
  a_start_pulse: assert property (p_start_pulse)
    else $error("flash start longer than one cycle");
  property p_start_after_sector; flash_start |-> sec_ok; endproperty
  a_start_after_sector: assert property (p_start_after_sector)
    else $error("flash start before a whole sector");
  property p_lba_hold; !flash_start |-> $stable(flash_lba); endproperty
  a_lba_hold: assert property (p_lba_hold)
    else $error("flash address moved between starts");
  property p_erase_flag;
    flash_start |-> flash_no_erase == (op_r == OP_WRITE_SEC_NOERASE
      || op_r == OP_WRITE_MULTI_NOERASE);
  endproperty
  a_erase_flag: assert property (p_erase_flag)
    else $error("no-erase flag does not match opcode");
  property p_intr_clear; $fell(intrq) |-> $past(pready && paddr[5:2] == IDX_CMD); endproperty
  a_intr_clear: assert property (p_intr_clear)
    else $error("interrupt dropped without a status access");
  c_no_erase: cover property (flash_start && flash_no_erase);
  c_word: cover property (buf_wvalid);
  c_intr: cover property ($rose(intrq));
endmodule
bind ata_pio_sector_write ata_write_sva #(.MAX_BLOCK(MAX_BLOCK), .SECTOR_WORDS(SECTOR_WORDS))
  ata_write_sva_i (.*);
`default_nettype wire

// file: sim/flash_model.sv
// Behavioural sector buffer and flash engine facing the write block.
// Assumes the bench sets the delay and the failing sector before a command.
`timescale 1ns/1ns
`default_nettype none
module flash_model (
  // Clock, reset and bench controls
  input wire logic mclk,
  input wire logic rst,
  input wire logic kick,
  input wire logic [7:0] delay,
  input wire logic [8:0] fail_at,
  // Engine side of the block
  input wire logic flash_start,
  output logic buf_ready,
  output logic flash_done,
  output logic flash_error
);
  logic [7:0] cnt;
  logic [8:0] nsec;
  logic pend;
  assign buf_ready = !pend && cnt == 8'h00;
  always_ff @(posedge mclk) begin
    flash_done <= 1'b0;
    // Outside a done pulse the error line means nothing, so it keeps moving.
    flash_error <= ~flash_error;
    if (rst) begin
      cnt <= 8'h00;
      nsec <= 9'h000;
      pend <= 1'b0;
    end else if (kick) begin
      cnt <= delay;
      nsec <= 9'h000;
    end else if (flash_start) begin
      // An unerased sector is simply written, so no-erase needs nothing here.
      pend <= 1'b1;
      cnt <= delay;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end else if (pend) begin
      pend <= 1'b0;
      flash_done <= 1'b1;
      flash_error <= (nsec == fail_at);
      nsec <= nsec + 9'h001;
      cnt <= delay;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb.sv
// Self-checking bench for the ATA PIO write block over APB.
// Assumes short sectors of four words and the flash model on the far side.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ata_write_pkg::*;
  localparam int SW = 4;
  localparam logic [31:0] ST_RDY = 32'h0000_0040;
  localparam logic [31:0] ST_DRQ = 32'h0000_0048;
  localparam logic [31:0] ST_ERR = 32'h0000_0041;
  logic mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, kick = 1'b0;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, intrq, buf_ready, buf_wvalid, flash_done, flash_error, flash_start;
  logic flash_lba_mode, flash_no_erase, se, intrq_d;
  logic [15:0] buf_wdata;
  logic [27:0] flash_lba, exp_lba;
  logic [7:0] delay = 8'h00;
  logic [8:0] fail_at = 9'h1FF;
  logic [31:0] cfg [4] = '{32'h0000_0000, 32'h0000_0100, 32'h0000_0004, 32'h0000_0101};
  int fail_count = 0, compares = 0, nint = 0, nstart = 0;
  always #50 mclk = ~mclk;
  ata_pio_sector_write #(.SECTOR_WORDS(SW)) ata_pio_sector_write_i (.mclk(mclk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .intrq(intrq),
    .buf_ready(buf_ready), .buf_wdata(buf_wdata), .buf_wvalid(buf_wvalid),
    .flash_done(flash_done), .flash_error(flash_error), .flash_start(flash_start),
    .flash_lba(flash_lba), .flash_lba_mode(flash_lba_mode), .flash_no_erase(flash_no_erase));
  flash_model flash_model_i (.mclk(mclk), .rst(rst), .kick(kick), .delay(delay),
    .fail_at(fail_at), .flash_start(flash_start), .buf_ready(buf_ready),
    .flash_done(flash_done), .flash_error(flash_error));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] w8(input logic [7:0] v);
    return {24'h00_0000, v};
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [3:0] idx, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    @(posedge mclk);
    while (pready !== 1'b1 && n < 2000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 2000) fail_count++;
    q = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] idx, input logic [31:0] e, input string nm);
    apb(1'b0, idx, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  task automatic wint();
    int n;
    n = 0;
    while (intrq !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) fail_count++;
  endtask
  // Flash activity and interrupt edges are tallied against the running command.
  always @(posedge mclk) begin
    intrq_d <= intrq;
    if (intrq === 1'b1 && intrq_d !== 1'b1) nint = nint + 1;
    if (flash_start === 1'b1) begin
      chk("flash_lba", {4'h1, exp_lba}, {3'h0, flash_lba_mode, flash_lba});
      exp_lba = exp_lba + 28'h000_0001;
      nstart = nstart + 1;
    end
  end
  task automatic run(input logic [7:0] op, input logic [7:0] cnt, input logic [7:0] bsz,
                     input logic [27:0] lba, input int fail, input logic [7:0] dly);
    int n, b, s, k, nb;
    n = (cnt == 8'h00) ? 256 : int'(cnt);
    b = (op == OP_WRITE_MULTI || op == OP_WRITE_MULTI_NOERASE) ? int'(bsz) : 1;
    fail_at <= (fail < 0) ? 9'h1FF : 9'(fail);
    delay <= dly;
    apb(1'b1, IDX_MULTI_CFG, {23'h00_0000, 1'b1, bsz});
    apb(1'b1, IDX_COUNT, w8(cnt));
    apb(1'b1, IDX_SECNUM, w8(lba[7:0]));
    apb(1'b1, IDX_CYL_LO, w8(lba[15:8]));
    apb(1'b1, IDX_CYL_HI, w8(lba[23:16]));
    apb(1'b1, IDX_DRVHD, w8({4'hE, lba[27:24]}));
    kick <= 1'b1;
    @(posedge mclk);
    kick <= 1'b0;
    exp_lba = lba;
    nint = 0;
    nstart = 0;
    apb(1'b1, IDX_CMD, w8(op));
    if (dly > 8'h08) begin
      apb(1'b0, IDX_CMD, 32'h0000_0000);
      chk("busy after command", 32'h0000_0080, q & 32'h0000_0088);
    end
    s = 0;
    nb = 0;
    while (s < n) begin
      k = (n - s < b) ? n - s : b;
      if (s == 0) begin
        q = 32'h0000_0000;
        for (int i = 0; i < 300 && q !== ST_DRQ; i++) apb(1'b0, IDX_CMD, 32'h0000_0000);
        chk("first drq", ST_DRQ, q);
      end else begin
        wint();
        rdc(IDX_CMD, ST_DRQ, "block drq");
      end
      nb++;
      for (int w = 0; w < k * SW; w++) apb(1'b1, IDX_DATA, {16'h0000, 8'(s + w / SW), 8'(w)});
      s += k;
      if (fail >= 0 && fail < s) break;
    end
    wint();
    rdc(IDX_CMD, (fail >= 0) ? ST_ERR : ST_RDY, "end status");
    rdc(IDX_COUNT, (fail >= 0) ? 32'(n - fail) : 32'h0000_0000, "residual");
    rdc(IDX_SECNUM, w8(8'(lba + ((fail >= 0) ? fail : n - 1))), "address");
    if (fail >= 0) rdc(IDX_FEATURE, 32'h0000_0040, "flash cause");
    chk("interrupts", nb, nint);
    chk("flash starts", (fail >= 0) ? fail + 1 : n, nstart);
    $display("test opcode %h count %h done", op, cnt);
  endtask
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    #4_000_000;
    fail_count++;
    $display("watchdog expired");
    test_done();
  end
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    rdc(IDX_COUNT, 32'h0000_0001, "count reset");
    rdc(IDX_SECNUM, 32'h0000_0001, "secnum reset");
    rdc(IDX_DRVHD, 32'h0000_00A0, "drvhd reset");
    rdc(IDX_CMD, ST_RDY, "status reset");
    rdc(4'hC, 32'h0000_0000, "unmapped data");
    chk("unmapped error", 32'h0000_0001, {31'h0000_0000, se});
    $display("test reset and map done");
    foreach (cfg[i]) begin
      apb(1'b1, IDX_MULTI_CFG, cfg[i]);
      apb(1'b1, IDX_CMD, w8(i == 3 ? 8'h32 : OP_WRITE_MULTI));
      wint();
      rdc(IDX_CMD, ST_ERR, "abort status");
      rdc(IDX_FEATURE, 32'h0000_0004, "abort cause");
    end
    $display("test abort done");
    run(OP_WRITE_SEC, 8'h02, 8'h01, 28'h000_00FF, -1, 8'h14);
    run(OP_WRITE_SEC_NR, 8'h01, 8'h01, 28'h123_4567, -1, 8'h00);
    run(OP_WRITE_SEC_NOERASE, 8'h00, 8'h01, 28'h0FF_FF80, -1, 8'h00);
    run(OP_WRITE_SEC, 8'h03, 8'h01, 28'h000_0040, 1, 8'h01);
    run(OP_WRITE_MULTI, 8'h05, 8'h02, 28'h5A3_B2FE, -1, 8'h03);
    run(OP_WRITE_MULTI_NOERASE, 8'h02, 8'h01, 28'h000_0010, -1, 8'h00);
    run(OP_WRITE_MULTI, 8'h08, 8'h04, 28'h000_0100, 2, 8'h02);
    test_done();
  end
endmodule
`default_nettype wire
